// [rtl/pin_wake_source_select.sv]
// pin wake source selection with apb register access
// assumes asynchronous pins and an apb master on i_mclk
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pin_wake_source_select
  import wake_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // wake pins
  input wire logic i_multifunction_pin_4,
  input wire logic i_multifunction_pin_52,
  input wire logic i_multifunction_pin_55,
  input wire logic i_pushbutton_input,
  input wire logic i_serial_receive,
  // to the power-mode controller
  output logic o_wake_req
);

  // ==========================================================
  // address decode
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] idx);
    reg_hit = (addr == {idx[ADDR_W-IDX_SHIFT-1:0], 2'b00});
  endfunction

  // ==========================================================
  // state
  apb_state_t apb_state_ff;
  logic [NSRC-1:0] wake_en_ff;
  logic [CFG_W-1:0] pin_cfg_ff;
  logic [NSRC-1:0] cause_ff;
  logic [NSRC-1:0] raw_pins;
  logic [NSRC-1:0] pin_level;
  logic [NSRC-1:0] pin_rise;
  logic [NSRC-1:0] qual;
  logic [NSRC-1:0] trig;
  logic [NSRC-1:0] wake_src;
  logic nxt_wake_req;
  logic hit_en;
  logic hit_cfg;
  logic hit_stat;
  logic hit_cause;
  logic mapped;
  logic read_only;
  logic wr_fire;
  logic [DATA_W-1:0] nxt_prdata;

  // ==========================================================
  // pin conditioning
  assign raw_pins[BIT_MP55] = i_multifunction_pin_55;
  assign raw_pins[BIT_MP52] = i_multifunction_pin_52;
  assign raw_pins[BIT_MP4] = i_multifunction_pin_4;
  assign raw_pins[BIT_PB] = i_pushbutton_input;
  assign raw_pins[BIT_RX] = i_serial_receive;

  pin_sync #(
    .W(NSRC)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pin(raw_pins),
    .o_level(pin_level),
    .o_rise(pin_rise)
  );

  // ==========================================================
  // source qualification
  // multifunction pins only count while configured as digital inputs;
  // otherwise toggling outputs or lcd drive would wake the part
  assign qual[BIT_MP55] = pin_cfg_ff[CFG_MP55];
  assign qual[BIT_MP52] = pin_cfg_ff[CFG_MP52];
  assign qual[BIT_MP4] = pin_cfg_ff[CFG_MP4];
  assign qual[BIT_PB] = 1'b1;
  assign qual[BIT_RX] = 1'b1;

  // edge sources use the rise pulse, the pushbutton its level
  assign trig = (pin_rise & EDGE_MASK) | (pin_level & LEVEL_MASK);

  assign wake_src = trig & wake_en_ff & qual;
  assign nxt_wake_req = |wake_src;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_wake_req <= 1'b0;
    end
    else
    begin
      o_wake_req <= nxt_wake_req;
    end
  end

  // ==========================================================
  // apb decode
  assign hit_en = reg_hit(i_paddr, IDX_WAKE_EN);
  assign hit_cfg = reg_hit(i_paddr, IDX_PIN_CFG);
  assign hit_stat = reg_hit(i_paddr, IDX_PIN_STAT);
  assign hit_cause = reg_hit(i_paddr, IDX_WAKE_CAUSE);
  assign mapped = hit_en || hit_cfg || hit_stat || hit_cause;
  assign read_only = hit_stat;

  // writes land only at the edge where pready is sampled high
  assign wr_fire = (apb_state_ff == APB_DONE) && i_psel && i_penable &&
                   i_pwrite && i_pstrb[0] && mapped && !read_only;

  always_comb
  begin
    nxt_prdata = '0;
    if (hit_en)
    begin
      nxt_prdata[NSRC-1:0] = wake_en_ff;
    end
    else if (hit_cfg)
    begin
      nxt_prdata[CFG_W-1:0] = pin_cfg_ff;
    end
    else if (hit_stat)
    begin
      nxt_prdata[NSRC-1:0] = pin_level;
      nxt_prdata[STAT_WAKE_BIT] = o_wake_req;
    end
    else if (hit_cause)
    begin
      nxt_prdata[NSRC-1:0] = cause_ff;
    end
  end

  // ==========================================================
  // apb handshake: one wait cycle, answer from registers
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      apb_state_ff <= APB_IDLE;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= RDATA_RST;
    end
    else
    begin
      case (apb_state_ff)
        APB_IDLE:
        begin
          if (i_psel && i_penable)
          begin
            apb_state_ff <= APB_DONE;
            o_pready <= 1'b1;
            o_pslverr <= !mapped || (i_pwrite && read_only);
            o_prdata <= i_pwrite ? RDATA_RST : nxt_prdata;
          end
        end
        APB_DONE:
        begin
          apb_state_ff <= APB_IDLE;
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
        end
        default:
        begin
          apb_state_ff <= APB_IDLE;
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wake_en_ff <= WAKE_EN_RST;
    end
    else if (wr_fire && hit_en)
    begin
      wake_en_ff <= i_pwdata[NSRC-1:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_cfg_ff <= PIN_CFG_RST;
    end
    else if (wr_fire && hit_cfg)
    begin
      pin_cfg_ff <= i_pwdata[CFG_W-1:0];
    end
  end

  // sticky cause, write 1 to clear; a new wake beats a same-cycle clear
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cause_ff <= CAUSE_RST;
    end
    else if (wr_fire && hit_cause)
    begin
      cause_ff <= (cause_ff & ~i_pwdata[NSRC-1:0]) | wake_src;
    end
    else
    begin
      cause_ff <= cause_ff | wake_src;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  mp4_rise_wake_a: assert property (
    pin_rise[BIT_MP4] && wake_en_ff[BIT_MP4] && pin_cfg_ff[CFG_MP4]
    |=> o_wake_req && cause_ff[BIT_MP4])
    else $error("pin 4 rise did not wake");

  mp4_qualify_a: assert property (
    $rose(cause_ff[BIT_MP4]) |-> $past(pin_cfg_ff[CFG_MP4]))
    else $error("pin 4 woke while not a digital input");

  mp52_rise_wake_a: assert property (
    pin_rise[BIT_MP52] && wake_en_ff[BIT_MP52] && pin_cfg_ff[CFG_MP52]
    |=> o_wake_req && cause_ff[BIT_MP52])
    else $error("pin 52 rise did not wake");

  mp52_qualify_a: assert property (
    $rose(cause_ff[BIT_MP52]) |-> $past(pin_cfg_ff[CFG_MP52]))
    else $error("pin 52 woke while not a digital input");

  mp55_rise_wake_a: assert property (
    pin_rise[BIT_MP55] && wake_en_ff[BIT_MP55] && pin_cfg_ff[CFG_MP55]
    |=> o_wake_req && cause_ff[BIT_MP55])
    else $error("pin 55 rise did not wake");

  mp55_qualify_a: assert property (
    $rose(cause_ff[BIT_MP55]) |-> $past(pin_cfg_ff[CFG_MP55]))
    else $error("pin 55 woke while not a digital input");

  pb_level_wake_a: assert property (
    (wake_en_ff[BIT_PB] && pin_level[BIT_PB]) [*2] |-> o_wake_req)
    else $error("pushbutton high level did not hold wake");

  pb_no_qual_a: assert property (
    wake_en_ff[BIT_PB] && pin_level[BIT_PB] && (pin_cfg_ff == PIN_CFG_RST)
    |=> o_wake_req ##0 cause_ff[BIT_PB])
    else $error("pushbutton wake blocked by pin configuration");

  rx_rise_wake_a: assert property (
    pin_rise[BIT_RX] && wake_en_ff[BIT_RX]
    |=> o_wake_req && cause_ff[BIT_RX])
    else $error("serial receive rise did not wake");

  wake_cause_a: assert property (
    o_wake_req |-> $past(wake_en_ff) != WAKE_EN_RST)
    else $error("wake request with no source enabled");

  apb_answer_a: assert property (
    i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb answer not one cycle after access");

endmodule

`default_nettype wire

// [shared/wake_pkg.sv]
// wake source selection: shared constants, register map and types
// assumes an apb master with 32-bit data and a 16-bit byte address
package wake_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_SHIFT = 2;

  // ==========================================================
  // register indexes, byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_WAKE_EN = 16'h28B3;
  localparam logic [ADDR_W-1:0] IDX_PIN_CFG = 16'h28B4;
  localparam logic [ADDR_W-1:0] IDX_PIN_STAT = 16'h28B5;
  localparam logic [ADDR_W-1:0] IDX_WAKE_CAUSE = 16'h28B6;

  // ==========================================================
  // wake source bit positions, shared by enable, status and cause
  localparam int unsigned NSRC = 5;
  localparam int unsigned BIT_MP55 = 0;
  localparam int unsigned BIT_MP52 = 1;
  localparam int unsigned BIT_MP4 = 2;
  localparam int unsigned BIT_PB = 3;
  localparam int unsigned BIT_RX = 4;
  localparam int unsigned STAT_WAKE_BIT = 5;

  // sources that wake on a rising edge, the rest wake on a high level
  localparam logic [NSRC-1:0] EDGE_MASK = 5'h17;
  localparam logic [NSRC-1:0] LEVEL_MASK = 5'h08;

  // ==========================================================
  // pin configuration register: 1 means pin is a digital input
  localparam int unsigned CFG_W = 3;
  localparam int unsigned CFG_MP55 = 0;
  localparam int unsigned CFG_MP52 = 1;
  localparam int unsigned CFG_MP4 = 2;

  // ==========================================================
  // reset values
  localparam logic [NSRC-1:0] WAKE_EN_RST = 5'h00;
  localparam logic [CFG_W-1:0] PIN_CFG_RST = 3'h0;
  localparam logic [NSRC-1:0] CAUSE_RST = 5'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // apb slave phase
  typedef enum logic [1:0]
  {
    APB_IDLE = 2'b01,
    APB_DONE = 2'b10
  } apb_state_t;

endpackage

// [rtl/pin_sync.sv]
// pin input conditioning: three-stage synchroniser and rising-edge pulse
// assumes asynchronous pins; level changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 5
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // raw pins
  input wire logic [W-1:0] i_pin,
  // conditioned outputs
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise
);

  // ==========================================================
  // synchroniser stages
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // ==========================================================
  // accepted level and edge, per pin
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : gen_pin
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
        begin
          o_level[g] <= 1'b0;
          o_rise[g] <= 1'b0;
        end
        else
        begin
          // a half-settled sample never counts as a change
          if (s2_ff[g] == s3_ff[g])
          begin
            o_level[g] <= s3_ff[g];
          end
          o_rise[g] <= (s2_ff[g] == s3_ff[g]) && s3_ff[g] && !o_level[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [sim/pin_source_model.sv]
// far side model: pushbutton, serial line and multifunction pins
// assumes the bench asks for pin levels in the package bit order
`timescale 1ns/1ps
`default_nettype none

module pin_source_model
  import wake_pkg::*;
(
  // clock
  input wire logic i_mclk,
  // requested levels, one bit per source
  input wire logic [NSRC-1:0] i_level,
  // pins toward the device
  output logic o_multifunction_pin_4,
  output logic o_multifunction_pin_52,
  output logic o_multifunction_pin_55,
  output logic o_pushbutton_input,
  output logic o_serial_receive
);
  // ==========================================================
  // pins move just after an edge, like real slow external lines
  initial
  begin
    o_multifunction_pin_4 = 1'b0;
    o_multifunction_pin_52 = 1'b0;
    o_multifunction_pin_55 = 1'b0;
    o_pushbutton_input = 1'b0;
    o_serial_receive = 1'b0;
  end

  always @(posedge i_mclk)
  begin
    o_multifunction_pin_55 <= i_level[BIT_MP55];
    o_multifunction_pin_52 <= i_level[BIT_MP52];
    o_multifunction_pin_4 <= i_level[BIT_MP4];
    o_pushbutton_input <= i_level[BIT_PB];
    o_serial_receive <= i_level[BIT_RX];
  end
endmodule

`default_nettype wire

// [sim/pin_wake_source_select_tb.sv]
// self-checking bench for the pin wake source selection block
// assumes the apb answer carries one wait state but waits for pready
`timescale 1ns/1ps
`default_nettype none

module pin_wake_source_select_tb
  import wake_pkg::*;
;
  typedef struct packed
  {
    logic [4:0] en;
    logic [2:0] cfg;
    logic [4:0] pin;
    logic wake;
    logic hold;
  } row_t;
  localparam row_t ROWS [10] = '{
    '{5'h04, 3'h4, 5'h04, 1'b1, 1'b0}, '{5'h04, 3'h3, 5'h04, 1'b0, 1'b0},
    '{5'h02, 3'h2, 5'h02, 1'b1, 1'b0}, '{5'h02, 3'h5, 5'h02, 1'b0, 1'b0},
    '{5'h01, 3'h1, 5'h01, 1'b1, 1'b0}, '{5'h01, 3'h6, 5'h01, 1'b0, 1'b0},
    '{5'h08, 3'h0, 5'h08, 1'b1, 1'b1}, '{5'h10, 3'h0, 5'h10, 1'b1, 1'b0},
    '{5'h0F, 3'h7, 5'h10, 1'b0, 1'b0}, '{5'h1F, 3'h7, 5'h11, 1'b1, 1'b0}};
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [ADDR_W-1:0] i_paddr = '0;
  logic [DATA_W-1:0] i_pwdata = '0;
  logic [3:0] i_pstrb = 4'h0;
  logic [DATA_W-1:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic [NSRC-1:0] lvl = '0;
  logic mp4, mp52, mp55, pb, rx, o_wake_req, seen;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] exp_v;
  logic err;
  int n_errors = 0;
  int check_count = 0;

  always #4 i_mclk = ~i_mclk;

  pin_source_model i_pin_source_model (.i_mclk(i_mclk), .i_level(lvl),
    .o_multifunction_pin_4(mp4), .o_multifunction_pin_52(mp52),
    .o_multifunction_pin_55(mp55), .o_pushbutton_input(pb),
    .o_serial_receive(rx));

  pin_wake_source_select i_pin_wake_source_select (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_multifunction_pin_4(mp4),
    .i_multifunction_pin_52(mp52), .i_multifunction_pin_55(mp55),
    .i_pushbutton_input(pb), .i_serial_receive(rx),
    .o_wake_req(o_wake_req));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] idx,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= idx << IDX_SHIFT;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    @(posedge i_mclk);
    while (o_pready !== 1'b1 && n < 20)
    begin
      @(posedge i_mclk);
      n++;
    end
    // a missing answer counts once, whatever the loop count reached
    if (o_pready !== 1'b1)
    begin
      n_errors++;
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_mclk);
  endtask

  // wake seen in any of the next n cycles
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge i_mclk);
      seen = seen | o_wake_req;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog, far beyond the fewer than one thousand cycles of the tests
  initial
  begin
    #200000;
    n_errors++;
    report_and_stop;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge i_mclk);
    chk(o_wake_req, 1'b0);
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    apb(1'b0, IDX_WAKE_EN, '0, 4'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, IDX_PIN_CFG, '0, 4'h0);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
    // sources only reach the request when enabled and qualified
    foreach (ROWS[i])
    begin
      apb(1'b1, IDX_WAKE_EN, 32'(ROWS[i].en), 4'hF);
      apb(1'b1, IDX_PIN_CFG, 32'(ROWS[i].cfg), 4'hF);
      lvl <= ROWS[i].pin;
      watch(12);
      chk(seen, ROWS[i].wake);
      watch(12);
      chk(o_wake_req, ROWS[i].hold);
      apb(1'b0, IDX_PIN_STAT, '0, 4'h0);
      exp_v = 32'(ROWS[i].pin) | (32'(ROWS[i].hold) << STAT_WAKE_BIT);
      chk(rd, exp_v);
      lvl <= '0;
      watch(12);
      apb(1'b0, IDX_WAKE_CAUSE, '0, 4'h0);
      exp_v = ROWS[i].wake ? 32'(ROWS[i].pin) : 32'h0000_0000;
      chk(rd, exp_v);
      apb(1'b1, IDX_WAKE_CAUSE, 32'h0000_001F, 4'hF);
      apb(1'b0, IDX_WAKE_CAUSE, '0, 4'h0);
      chk(rd, 32'h0000_0000);
      $display("row %0d done", i);
    end
    // awkward register accesses
    apb(1'b1, IDX_WAKE_EN, 32'h0000_0000, 4'hE);
    apb(1'b0, IDX_WAKE_EN, '0, 4'h0);
    chk(rd, 32'h0000_001F);
    apb(1'b1, IDX_PIN_STAT, 32'h0000_001F, 4'hF);
    chk(err, 1'b1);
    apb(1'b0, 16'h0100, '0, 4'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("register test done");
    // a rising pin held high wakes only once
    apb(1'b1, IDX_WAKE_EN, 32'h0000_0004, 4'hF);
    apb(1'b1, IDX_PIN_CFG, 32'h0000_0004, 4'hF);
    lvl <= 5'h04;
    watch(12);
    chk(seen, 1'b1);
    watch(30);
    chk(seen, 1'b0);
    // a second reset clears the enables again
    i_rst <= 1'b1;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    lvl <= 5'h1F;
    watch(15);
    chk(seen, 1'b0);
    apb(1'b0, IDX_WAKE_EN, '0, 4'h0);
    chk(rd, 32'h0000_0000);
    $display("edge and reset test done");
    report_and_stop;
  end
endmodule

`default_nettype wire
